// ===== core/csf_status_word.sv
// CPU status word register with flag update and jump condition test
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "csf_defines.svh"
// Behaviour
// - Status word is 8-bit read/write register at byte address 0FCh.
// - Carry bit 7 set on carry out of or borrow into bit 7.
// - Rotates shift carry in and catch the shifted-out bit in carry.
// - Zero bit 6 set when the result is zero, cleared otherwise.
// - Sign bit 5 takes the result's top bit after result-producing operations.
// - Overflow bit 4 set when signed result leaves the 8-bit range.
// - Decimal-adjust bit 3 records add (0) versus subtract (1).
// - Half-carry bit 2 set on carry out of or borrow into bit 3.
// - User bits 1 and 0 change only by software writes.
// - A 4-bit condition field selects one of sixteen flag tests.
// - Jump taken only if the test holds; 0000 never, 1000 always.
// - Code 0001 is sign XOR overflow; 1001 is its inverse.
// - Code 0010 is zero OR (sign XOR overflow); 1010 its inverse.
// - Code 0011 is carry OR zero; 1011 is both clear.
// - Codes 0100-0111 test overflow, sign, zero, carry set; 1100-1111 clear.
module csf_status_word (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`CSF_ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic aluValid,
	input wire csf_pkg::csf_op_t aluOp,
	input wire logic [7:0] aluA,
	input wire logic [7:0] aluB,
	output logic [7:0] aluResult,
	input wire logic ccValid,
	input wire csf_pkg::csf_cc_t ccCode,
	output logic jumpValid,
	output logic jumpTaken,
	output logic [7:0] flagsOut
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	csf_alu_if alu ();
	csf_pkg::csf_bus_state_t bus_reg;
	csf_pkg::csf_bus_state_t bus_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] result_reg;
	logic [7:0] result_next;
	logic jumpValid_reg;
	logic jumpValid_next;
	logic jumpTaken_reg;
	logic jumpTaken_next;
	logic condTrue;
	logic busReq;
	logic hitStatus;
	logic swWrite;

	// ****************************************************************
	// Flag calculation and condition test
	// ****************************************************************

	// Operands come straight from the ports, carry from the current status word
	assign alu.op = aluOp;
	assign alu.opA = aluA;
	assign alu.opB = aluB;
	assign alu.carryIn = flags_reg[`CSF_BIT_CARRY];

	csf_flag_calc u_calc (
		.alu(alu.calc)
	);

	csf_cond_eval u_cond (
		.flags(flags_reg),
		.code(ccCode),
		.taken(condTrue)
	);

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************

	// One-wait answer: ack rises the edge after the request and drops next
	assign busReq = wb_cyc_i && wb_stb_i && (bus_reg == csf_pkg::CSF_BUS_IDLE);
	assign hitStatus = (wb_adr_i == `CSF_STATUS_OFFSET);
	assign swWrite = busReq && wb_we_i && hitStatus && wb_sel_i[0];

	// Handshake state and read data
	always_comb begin
		bus_next = csf_pkg::CSF_BUS_IDLE;
		rdata_next = rdata_reg;
		case (bus_reg)
			csf_pkg::CSF_BUS_IDLE: begin
				if (busReq) begin
					bus_next = csf_pkg::CSF_BUS_ACK;
					// Unmapped reads answer zero; bits above the byte read zero
					rdata_next = hitStatus ? {24'h000000, flags_reg} : 32'h00000000;
				end
			end
			csf_pkg::CSF_BUS_ACK: begin
				bus_next = csf_pkg::CSF_BUS_IDLE;
			end
			default: begin
				bus_next = csf_pkg::CSF_BUS_IDLE;
			end
		endcase
	end

	// Bus registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_reg <= csf_pkg::CSF_BUS_IDLE;
			rdata_reg <= 32'h00000000;
		end else begin
			bus_reg <= bus_next;
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_o = bus_reg[1]; // One-hot code: this bit is the ack state flop
	assign wb_dat_o = rdata_reg;

	// ****************************************************************
	// Status word
	// ****************************************************************

	// Software write wins over an operation in the same cycle
	always_comb begin
		flags_next = flags_reg;
		result_next = result_reg;
		if (swWrite) begin
			flags_next = wb_dat_i[7:0];
		end else if (aluValid) begin
			// Masked merge keeps the user bits out of reach of results
			flags_next = (alu.newFlags & alu.updMask) |
				(flags_reg & ~alu.updMask);
		end
		if (aluValid) begin
			result_next = alu.result;
		end
	end

	// No reset on the status word: contents stay unknown until written
	always_ff @(posedge clk) begin
		flags_reg <= flags_next;
	end

	// Result register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= 8'h00;
		end else begin
			result_reg <= result_next;
		end
	end

	assign aluResult = result_reg;
	assign flagsOut = flags_reg;

	// ****************************************************************
	// Conditional jump answer
	// ****************************************************************

	// Tested against the flags held at the request edge
	always_comb begin
		jumpValid_next = ccValid;
		jumpTaken_next = ccValid && condTrue;
	end

	// Jump answer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			jumpValid_reg <= 1'b0;
			jumpTaken_reg <= 1'b0;
		end else begin
			jumpValid_reg <= jumpValid_next;
			jumpTaken_reg <= jumpTaken_next;
		end
	end

	assign jumpValid = jumpValid_reg;
	assign jumpTaken = jumpTaken_reg;

	// ****************************************************************
	// Assertion helper
	// ****************************************************************
	logic flagsKnown_reg;
	logic flagsKnown_next;

	// Set once software has written the whole word; before that checks would see unknowns
	always_comb begin
		flagsKnown_next = flagsKnown_reg || swWrite;
	end

	// Cleared by reset on purpose, although the status word itself keeps its value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flagsKnown_reg <= 1'b0;
		end else begin
			flagsKnown_reg <= flagsKnown_next;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************

	a_bus_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		swWrite |=> wb_ack_o && flagsOut == $past(wb_dat_i[7:0]))
		else $error("status word write not stored");

	a_bus_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");

	a_add_carry_out: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_ADD) |=>
		flagsOut[7] == (({1'b0, $past(aluA)} + {1'b0, $past(aluB)}) > 9'h0ff))
		else $error("carry wrong after add");

	a_rot_through_carry: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_RLC) |=>
		flagsOut[7] == $past(aluA[7]) && aluResult[0] == $past(flagsOut[7]))
		else $error("rotate left through carry wrong");

	a_zero_sign_track: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp != csf_pkg::CSF_OP_NOP) |=>
		flagsOut[6] == (aluResult == 8'h00) && flagsOut[5] == aluResult[7])
		else $error("zero or sign flag disagrees with result");

	a_sub_overflow: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_SUB) |=>
		flagsOut[4] == (($signed({$past(aluA[7]), $past(aluA)}) -
		$signed({$past(aluB[7]), $past(aluB)})) > 9'sd127 ||
		($signed({$past(aluA[7]), $past(aluA)}) -
		$signed({$past(aluB[7]), $past(aluB)})) < -9'sd128))
		else $error("overflow wrong after subtract");

	a_decadj_subtract: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_SBC) |=> flagsOut[3])
		else $error("decimal-adjust flag not set by subtract");

	a_half_carry_add: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_ADD) |=>
		flagsOut[2] == (({1'b0, $past(aluA[3:0])} + {1'b0, $past(aluB[3:0])}) > 5'h0f))
		else $error("half carry wrong after add");

	a_user_bits_kept: assert property (@(posedge clk) disable iff (!rst_n)
		(flagsKnown_reg && !swWrite) |=> flagsOut[1:0] == $past(flagsOut[1:0]))
		else $error("user bits changed without a write");

	a_cc_never_always: assert property (@(posedge clk) disable iff (!rst_n)
		(ccValid && ccCode[2:0] == 3'h0) |=> jumpValid && jumpTaken == $past(ccCode[3]))
		else $error("never or always code misbehaves");

	a_cc_signed_below: assert property (@(posedge clk) disable iff (!rst_n)
		(ccValid && ccCode == csf_pkg::CSF_CC_SIGNED_BELOW) |=>
		jumpTaken == ($past(flagsOut[5]) ^ $past(flagsOut[4])))
		else $error("signed below test wrong");

	a_cc_signed_above: assert property (@(posedge clk) disable iff (!rst_n)
		(ccValid && ccCode == csf_pkg::CSF_CC_SIGNED_ABOVE) |=>
		jumpTaken == !($past(flagsOut[6]) | ($past(flagsOut[5]) ^ $past(flagsOut[4]))))
		else $error("signed above test wrong");

	a_cc_unsigned_above: assert property (@(posedge clk) disable iff (!rst_n)
		(ccValid && ccCode == csf_pkg::CSF_CC_UNSIGNED_ABOVE) |=>
		jumpTaken == (!$past(flagsOut[7]) && !$past(flagsOut[6])))
		else $error("unsigned above test wrong");

	a_cc_carry_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(ccValid && ccCode == csf_pkg::CSF_CC_UNSIGNED_AT_LEAST) |=>
		jumpTaken == !$past(flagsOut[7]))
		else $error("carry clear test wrong");

	a_read_returns_word: assert property (@(posedge clk) disable iff (!rst_n)
		(busReq && !wb_we_i && hitStatus) |=> wb_dat_o == {24'h000000, $past(flagsOut)})
		else $error("status word read data wrong");

	a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(busReq && !hitStatus) |=> wb_dat_o == 32'h00000000)
		else $error("unmapped access returned nonzero data");

	a_sub_borrow_out: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_SUB) |=>
		flagsOut[7] == ($past(aluA) < $past(aluB)))
		else $error("carry wrong after subtract");

	a_rot_right_carry: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_RRC) |=>
		flagsOut[7] == $past(aluA[0]) && aluResult[7] == $past(flagsOut[7]))
		else $error("rotate right through carry wrong");

	a_logic_sign_ovfl: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_LOGIC) |=>
		flagsOut[5] == $past(aluA[7]) && !flagsOut[4])
		else $error("sign or overflow wrong after logic result");

	a_add_overflow: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_ADD) |=>
		flagsOut[4] == (($signed({$past(aluA[7]), $past(aluA)}) +
		$signed({$past(aluB[7]), $past(aluB)})) > 9'sd127 ||
		($signed({$past(aluA[7]), $past(aluA)}) +
		$signed({$past(aluB[7]), $past(aluB)})) < -9'sd128))
		else $error("overflow wrong after add");

	a_decadj_add: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && (aluOp == csf_pkg::CSF_OP_ADD ||
		aluOp == csf_pkg::CSF_OP_ADC)) |=> !flagsOut[3])
		else $error("decimal-adjust flag not cleared by add");

	a_half_borrow_sub: assert property (@(posedge clk) disable iff (!rst_n)
		(aluValid && !swWrite && aluOp == csf_pkg::CSF_OP_SUB) |=>
		flagsOut[2] == ($past(aluA[3:0]) < $past(aluB[3:0])))
		else $error("half carry wrong after subtract");

	a_cc_signed_at_most: assert property (@(posedge clk) disable iff (!rst_n)
		(ccValid && ccCode == csf_pkg::CSF_CC_SIGNED_AT_MOST) |=>
		jumpTaken == ($past(flagsOut[6]) | ($past(flagsOut[5]) ^ $past(flagsOut[4]))))
		else $error("signed at most test wrong");

	a_cc_unsigned_at_most: assert property (@(posedge clk) disable iff (!rst_n)
		(ccValid && ccCode == csf_pkg::CSF_CC_UNSIGNED_AT_MOST) |=>
		jumpTaken == ($past(flagsOut[7]) | $past(flagsOut[6])))
		else $error("unsigned at most test wrong");

endmodule // csf_status_word

// ===== core/csf_defines.svh
// Address, field position and bus constants of the CPU status word block
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CSF_ADR_W 12
`define CSF_STATUS_OFFSET 12'h0fc
`define CSF_STATUS_W 8

// ****************************************************************
// Status word field positions
// ****************************************************************
`define CSF_BIT_CARRY 7
`define CSF_BIT_ZERO 6
`define CSF_BIT_SIGN 5
`define CSF_BIT_OVFL 4
`define CSF_BIT_DECADJ 3
`define CSF_BIT_HALF 2
`define CSF_BIT_USER_ONE 1
`define CSF_BIT_USER_TWO 0

// ****************************************************************
// Flag update masks, one bit per status word field
// ****************************************************************
`define CSF_MASK_ARITH 8'hfc
`define CSF_MASK_LOGIC 8'h70
`define CSF_MASK_ROT 8'he0
`define CSF_MASK_NONE 8'h00

`endif

// ===== core/csf_pkg.sv
// Types shared by the CPU status word block
package csf_pkg;

	// ****************************************************************
	// Operations of the flag calculator; all but NOP update the status word
	// ****************************************************************
	typedef enum logic [2:0] {
		CSF_OP_ADD = 3'h0,
		CSF_OP_ADC = 3'h1,
		CSF_OP_SUB = 3'h2,
		CSF_OP_SBC = 3'h3,
		CSF_OP_LOGIC = 3'h4,
		CSF_OP_RLC = 3'h5,
		CSF_OP_RRC = 3'h6,
		CSF_OP_NOP = 3'h7
	} csf_op_t;

	// ****************************************************************
	// Condition field of conditional jumps
	// ****************************************************************
	typedef enum logic [3:0] {
		CSF_CC_NEVER = 4'h0,
		CSF_CC_SIGNED_BELOW = 4'h1,
		CSF_CC_SIGNED_AT_MOST = 4'h2,
		CSF_CC_UNSIGNED_AT_MOST = 4'h3,
		CSF_CC_ARITH_WRAP_TRUE = 4'h4,
		CSF_CC_NEGATIVE_RESULT = 4'h5,
		CSF_CC_OPERANDS_SAME = 4'h6,
		CSF_CC_UNSIGNED_BELOW = 4'h7,
		CSF_CC_ALWAYS = 4'h8,
		CSF_CC_SIGNED_AT_LEAST = 4'h9,
		CSF_CC_SIGNED_ABOVE = 4'ha,
		CSF_CC_UNSIGNED_ABOVE = 4'hb,
		CSF_CC_NO_ARITH_WRAP = 4'hc,
		CSF_CC_NONNEGATIVE_RESULT = 4'hd,
		CSF_CC_OPERANDS_DIFFER = 4'he,
		CSF_CC_UNSIGNED_AT_LEAST = 4'hf
	} csf_cc_t;

	// ****************************************************************
	// Idle-or-busy handshake state of the bus slave
	// ****************************************************************
	typedef enum logic [1:0] {
		CSF_BUS_IDLE = 2'b01,
		CSF_BUS_ACK = 2'b10
	} csf_bus_state_t;

endpackage

// ===== core/csf_alu_if.sv
// Carrier between the status word core and its flag calculator
`timescale 1ns/1ps
interface csf_alu_if;
	csf_pkg::csf_op_t op;
	logic [7:0] opA;
	logic [7:0] opB;
	logic carryIn;
	logic [7:0] result;
	logic [7:0] newFlags;
	logic [7:0] updMask;

	modport calc (input op, input opA, input opB, input carryIn,
		output result, output newFlags, output updMask);
	modport core (output op, output opA, output opB, output carryIn,
		input result, input newFlags, input updMask);
endinterface

// ===== core/csf_flag_calc.sv
// Combinational result and flag calculation for one operation
`timescale 1ns/1ps
`include "csf_defines.svh"
module csf_flag_calc (
	csf_alu_if.calc alu
);
	logic [8:0] wide;
	logic [4:0] nib;
	logic ci;

	// Carry chain, nibble chain and per-field flags
	always_comb begin
		ci = 1'b0;
		wide = 9'h000;
		nib = 5'h00;
		alu.result = alu.opA;
		alu.newFlags = 8'h00;
		alu.updMask = `CSF_MASK_NONE;
		case (alu.op)
			csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC: begin
				ci = (alu.op == csf_pkg::CSF_OP_ADC) ? alu.carryIn : 1'b0;
				wide = {1'b0, alu.opA} + {1'b0, alu.opB} + {8'h00, ci};
				nib = {1'b0, alu.opA[3:0]} + {1'b0, alu.opB[3:0]} + {4'h0, ci};
				alu.result = wide[7:0];
				alu.newFlags[`CSF_BIT_CARRY] = wide[8];
				alu.newFlags[`CSF_BIT_OVFL] = (alu.opA[7] == alu.opB[7]) &&
					(wide[7] != alu.opA[7]);
				alu.newFlags[`CSF_BIT_DECADJ] = 1'b0;
				alu.newFlags[`CSF_BIT_HALF] = nib[4];
				alu.updMask = `CSF_MASK_ARITH;
			end
			csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC: begin
				ci = (alu.op == csf_pkg::CSF_OP_SBC) ? alu.carryIn : 1'b0;
				wide = {1'b0, alu.opA} - {1'b0, alu.opB} - {8'h00, ci};
				nib = {1'b0, alu.opA[3:0]} - {1'b0, alu.opB[3:0]} - {4'h0, ci};
				alu.result = wide[7:0];
				alu.newFlags[`CSF_BIT_CARRY] = wide[8];
				alu.newFlags[`CSF_BIT_OVFL] = (alu.opA[7] != alu.opB[7]) &&
					(wide[7] != alu.opA[7]);
				alu.newFlags[`CSF_BIT_DECADJ] = 1'b1;
				alu.newFlags[`CSF_BIT_HALF] = nib[4];
				alu.updMask = `CSF_MASK_ARITH;
			end
			csf_pkg::CSF_OP_LOGIC: begin
				// Logical result arrives ready-made on opA; overflow cleared
				alu.updMask = `CSF_MASK_LOGIC;
			end
			csf_pkg::CSF_OP_RLC: begin
				alu.result = {alu.opA[6:0], alu.carryIn};
				alu.newFlags[`CSF_BIT_CARRY] = alu.opA[7];
				alu.updMask = `CSF_MASK_ROT;
			end
			csf_pkg::CSF_OP_RRC: begin
				alu.result = {alu.carryIn, alu.opA[7:1]};
				alu.newFlags[`CSF_BIT_CARRY] = alu.opA[0];
				alu.updMask = `CSF_MASK_ROT;
			end
			default: begin
				alu.updMask = `CSF_MASK_NONE;
			end
		endcase
		alu.newFlags[`CSF_BIT_ZERO] = (alu.result == 8'h00);
		alu.newFlags[`CSF_BIT_SIGN] = alu.result[7];
	end
endmodule // csf_flag_calc

// ===== core/csf_cond_eval.sv
// Condition field decoder for conditional jumps
`timescale 1ns/1ps
`include "csf_defines.svh"
module csf_cond_eval (
	input wire logic [7:0] flags,
	input wire csf_pkg::csf_cc_t code,
	output logic taken
);
	logic c;
	logic z;
	logic s;
	logic v;
	logic test;

	// Low three bits pick a test; the top bit inverts it
	always_comb begin
		c = flags[`CSF_BIT_CARRY];
		z = flags[`CSF_BIT_ZERO];
		s = flags[`CSF_BIT_SIGN];
		v = flags[`CSF_BIT_OVFL];
		case (code[2:0])
			3'h0: test = 1'b0;
			3'h1: test = s ^ v;
			3'h2: test = z | (s ^ v);
			3'h3: test = c | z;
			3'h4: test = v;
			3'h5: test = s;
			3'h6: test = z;
			3'h7: test = c;
			default: test = 1'b0;
		endcase
		taken = test ^ code[3];
	end
endmodule // csf_cond_eval

// ===== dv/csf_status_word_bench.sv
// Self-checking bench for the CPU status word block
`timescale 1ns/1ps
module csf_status_word_bench;
	// ****************************************************************
	// Clock, reset and design ports
	// ****************************************************************
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] wbAdr = 12'h000;
	logic [31:0] wbDatI = 32'h0;
	logic [31:0] wbDatO;
	logic wbWe = 1'b0;
	logic [3:0] wbSel = 4'h0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbAck;
	logic aluValid = 1'b0;
	csf_pkg::csf_op_t aluOp = csf_pkg::CSF_OP_NOP;
	logic [7:0] aluA = 8'h00;
	logic [7:0] aluB = 8'h00;
	logic [7:0] aluResult;
	logic ccValid = 1'b0;
	csf_pkg::csf_cc_t ccCode = csf_pkg::CSF_CC_NEVER;
	logic jumpValid;
	logic jumpTaken;
	logic [7:0] flagsOut;
	logic [31:0] rd;
	int fails = 0;
	int samplesChecked = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	csf_status_word csf_status_word_i (
		.clk(clk),
		.rst_n(rst_n),
		.wb_adr_i(wbAdr),
		.wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO),
		.wb_we_i(wbWe),
		.wb_sel_i(wbSel),
		.wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb),
		.wb_ack_o(wbAck),
		.aluValid(aluValid),
		.aluOp(aluOp),
		.aluA(aluA),
		.aluB(aluB),
		.aluResult(aluResult),
		.ccValid(ccValid),
		.ccCode(ccCode),
		.jumpValid(jumpValid),
		.jumpTaken(jumpTaken),
		.flagsOut(flagsOut)
	);

	// ****************************************************************
	// Shared helpers
	// ****************************************************************
	// Four-state compare, so an unknown never passes
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		samplesChecked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Classic single Wishbone cycle; the request is held until ack is sampled
	task automatic wb_cycle(input logic [11:0] adr, input logic we, input logic [3:0] sel,
		input logic [31:0] dat, output logic [31:0] data);
		int n;
		@(posedge clk);
		wbAdr <= adr;
		wbWe <= we;
		wbSel <= sel;
		wbDatI <= dat;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (wbAck === 1'b1) break;
		end
		data = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		if (n == 20) begin
			fails++;
			$display("[FAIL] wbAck expected 1 seen 0");
			end_sim();
		end
	endtask

	task automatic set_flags(input logic [7:0] v);
		wb_cycle(12'h0fc, 1'b1, 4'hf, {24'h0, v}, rd);
	endtask

	// One operation pulse; outputs are looked at once the taking edge has landed
	task automatic do_op(input csf_pkg::csf_op_t op, input logic [7:0] a, input logic [7:0] b);
		@(posedge clk);
		aluValid <= 1'b1;
		aluOp <= op;
		aluA <= a;
		aluB <= b;
		@(posedge clk);
		aluValid <= 1'b0;
		#1;
	endtask

	// Expected status word after add or subtract, user bits carried through
	function automatic logic [7:0] arith_flags(input logic sub, input logic [7:0] a,
		input logic [7:0] b, input logic cin, input logic [1:0] user, output logic [7:0] res);
		logic [8:0] full;
		logic [4:0] half;
		logic ovf;
		if (sub) begin
			full = {1'b0, a} - {1'b0, b} - {8'h0, cin};
			half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
			ovf = (a[7] != b[7]) && (full[7] != a[7]);
		end else begin
			full = {1'b0, a} + {1'b0, b} + {8'h0, cin};
			half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			ovf = (a[7] == b[7]) && (full[7] != a[7]);
		end
		res = full[7:0];
		return {full[8], full[7:0] == 8'h00, full[7], ovf, sub, half[4], user};
	endfunction

	// Expected jump decision; the upper half of the codes inverts the lower
	function automatic logic cond_exp(input logic [7:0] f, input logic [3:0] code);
		logic base;
		case (code[2:0])
			3'h0: base = 1'b0;
			3'h1: base = f[5] ^ f[4];
			3'h2: base = f[6] | (f[5] ^ f[4]);
			3'h3: base = f[7] | f[6];
			3'h4: base = f[4];
			3'h5: base = f[5];
			3'h6: base = f[6];
			default: base = f[7];
		endcase
		return base ^ code[3];
	endfunction

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Byte lane, unmapped read and unmapped write around the status word
	task automatic test_bus();
		set_flags(8'ha5);
		wb_cycle(12'h0fc, 1'b0, 4'hf, 32'h0, rd);
		check("status read", 32'h0000_00a5, rd);
		check("flagsOut", 32'h0000_00a5, {24'h0, flagsOut});
		wb_cycle(12'h0fc, 1'b1, 4'he, 32'h0000_005a, rd);
		wb_cycle(12'h0f8, 1'b0, 4'hf, 32'h0, rd);
		check("unmapped read", 32'h0, rd);
		wb_cycle(12'h100, 1'b1, 4'hf, 32'h0000_00ff, rd);
		wb_cycle(12'h0fc, 1'b0, 4'hf, 32'h0, rd);
		check("status kept", 32'h0000_00a5, rd);
		$display("test_bus done");
	endtask

	// Carry and borrow edges, signed wrap and zero result, carry-in from the word
	task automatic test_arith();
		csf_pkg::csf_op_t ops[5] = '{csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC,
			csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC, csf_pkg::CSF_OP_SUB};
		logic [7:0] as[5] = '{8'h7f, 8'hff, 8'h00, 8'h80, 8'h55};
		logic [7:0] bs[5] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h55};
		logic [7:0] pre[5] = '{8'h83, 8'h82, 8'h01, 8'h80, 8'h02};
		logic [7:0] expF;
		logic [7:0] expR;
		for (int i = 0; i < 5; i++) begin
			set_flags(pre[i]);
			do_op(ops[i], as[i], bs[i]);
			expF = arith_flags(ops[i][1], as[i], bs[i], ops[i][0] & pre[i][7], pre[i][1:0], expR);
			check("aluResult", {24'h0, expR}, {24'h0, aluResult});
			check("flagsOut", {24'h0, expF}, {24'h0, flagsOut});
		end
		$display("test_arith done");
	endtask

	// Rotates through carry, then logic and no-op keep the other fields
	task automatic test_rotate_logic();
		csf_pkg::csf_op_t ops[3] = '{csf_pkg::CSF_OP_RLC, csf_pkg::CSF_OP_RRC,
			csf_pkg::CSF_OP_RLC};
		logic [7:0] pre[3] = '{8'h81, 8'h02, 8'h00};
		logic [7:0] as[3] = '{8'h80, 8'h01, 8'h40};
		logic [7:0] expR[3] = '{8'h01, 8'h00, 8'h80};
		logic [7:0] expF[3] = '{8'h81, 8'hc2, 8'h20};
		for (int i = 0; i < 3; i++) begin
			set_flags(pre[i]);
			do_op(ops[i], as[i], 8'h00);
			check("rotate result", {24'h0, expR[i]}, {24'h0, aluResult});
			check("rotate flags", {24'h0, expF[i]}, {24'h0, flagsOut & 8'he3});
		end
		set_flags(8'hff);
		do_op(csf_pkg::CSF_OP_LOGIC, 8'h00, 8'h00);
		check("logic flags", 32'h0000_00cf, {24'h0, flagsOut});
		do_op(csf_pkg::CSF_OP_NOP, 8'h12, 8'h34);
		check("nop flags", 32'h0000_00cf, {24'h0, flagsOut});
		$display("test_rotate_logic done");
	endtask

	// All sixteen codes back to back for every carry, zero, sign, overflow mix
	task automatic test_cond();
		logic [7:0] f;
		for (int p = 0; p < 16; p++) begin
			f = {p[3:0], 4'h5};
			set_flags(f);
			for (int c = 0; c <= 16; c++) begin
				@(posedge clk);
				ccValid <= (c < 16);
				ccCode <= csf_pkg::csf_cc_t'(c[3:0]);
				#1;
				if (c > 0) begin
					check("jumpValid", 32'h1, {31'h0, jumpValid});
					check("jumpTaken", {31'h0, cond_exp(f, 4'(c - 1))}, {31'h0, jumpTaken});
				end
			end
			@(posedge clk);
			#1;
			check("jumpValid idle", 32'h0, {31'h0, jumpValid});
		end
		$display("test_cond done");
	endtask

	// Mid-run reset clears bus and result outputs but leaves the status word alone
	task automatic test_reset();
		set_flags(8'h3c);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("flags kept in reset", 32'h0000_003c, {24'h0, flagsOut});
		check("aluResult in reset", 32'h0, {24'h0, aluResult});
		check("ack in mid reset", 32'h0, {31'h0, wbAck});
		@(posedge clk);
		rst_n <= 1'b1;
		wb_cycle(12'h0fc, 1'b0, 4'hf, 32'h0, rd);
		check("flags after reset", 32'h0000_003c, rd);
		$display("test_reset done");
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (8) @(posedge clk);
		check("ack in reset", 32'h0, {31'h0, wbAck});
		check("jumpValid in reset", 32'h0, {31'h0, jumpValid});
		rst_n <= 1'b1;
		test_bus();
		test_arith();
		test_rotate_logic();
		test_cond();
		test_reset();
		end_sim();
	end
endmodule // csf_status_word_bench
